// *** bench/iow_field_model.sv ***
// Field-side model of the output drivers and their short reports
`timescale 1ns/10ps
module iow_field_model (
    input logic clk,
    input logic rst_n,
    input logic [11:0] do_pins,
    input logic [11:0] short_mask,
    output logic [11:0] sc_fault
);
    logic [11:0] short_ff;
    // A short shows once driven on, and stays after protection cuts it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            short_ff <= 12'h000;
        end else begin
            short_ff <= short_mask & (short_ff | do_pins);
        end
    end
    assign sc_fault = short_ff;
endmodule // iow_field_model

// *** bench/iow_io_guard_tb_top.sv ***
// Self-checking bench for the I/O guard timer block
`timescale 1ns/10ps
module iow_io_guard_tb_top;
    localparam int USC = 4;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic do_wr = 1'b0;
    logic [11:0] do_wdata = 12'h000;
    logic [11:0] short_mask = 12'h000;
    logic [11:0] do_latch, do_pins, sc_fault;
    logic [9:0] di_pins = 10'h2a5;
    logic [9:0] di_state;
    logic [2:0] overtemp = 3'h0;
    logic supply_low = 1'b0;
    iow_pkg::iow_diag_t diag_en = '0;
    iow_pkg::iow_diag_t diag;
    logic ao_wr = 1'b0;
    logic [31:0] ao_wdata = 32'h00000000;
    logic ao_ready, irq;
    logic [3:0][11:0] ao_out;
    iow_pkg::iow_tmr_cfg_t dcfg = '0;
    iow_pkg::iow_tmr_cfg_t acfg = '0;
    iow_pkg::iow_tmr_cmd_t dcmd = '0;
    iow_pkg::iow_tmr_cmd_t acmd = '0;
    iow_pkg::iow_tmr_stat_t dstat, astat;
    int errors = 0;
    int samples_checked = 0;
    int n;

    always #2.5 clk = ~clk;

    iow_io_guard #(.US_CYCLES(USC)) i_iow_io_guard (
        .CORE_CLK(clk), .RESET_N(rst_n), .DO_WR(do_wr),
        .DO_WDATA(do_wdata), .DO_LATCH(do_latch), .DO_PINS(do_pins),
        .DI_PINS(di_pins), .DI_STATE(di_state), .SC_FAULT(sc_fault),
        .OVERTEMP(overtemp), .SUPPLY_LOW(supply_low),
        .DIAG_IRQ_EN(diag_en), .DIAG(diag), .AO_WR(ao_wr),
        .AO_WDATA(ao_wdata), .AO_READY(ao_ready), .AO_OUT(ao_out),
        .DIG_GUARD_CFG(dcfg), .DIG_GUARD_CMD(dcmd),
        .DIG_GUARD_STAT(dstat), .ANA_GUARD_CFG(acfg),
        .ANA_GUARD_CMD(acmd), .ANA_GUARD_STAT(astat), .IRQ(irq)
    );

    iow_field_model i_iow_field_model (
        .clk(clk), .rst_n(rst_n), .do_pins(do_pins),
        .short_mask(short_mask), .sc_fault(sc_fault)
    );

    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp,
                       input string what);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask

    task automatic settle(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask

    function automatic logic sel_val(input int sel);
        case (sel)
            0: return ao_ready === 1'b1;
            1: return dstat.timed_out === 1'b1;
            2: return astat.timed_out === 1'b1;
            3: return dstat.count === 12'h001;
            4: return astat.count === 12'h001;
            default: return dstat.irq_flag === 1'b1;
        endcase
    endfunction

    // Counts edges until the condition holds; n keeps the count
    task automatic wait_on(input int sel, input int lim);
        n = 0;
        while (!sel_val(sel) && n < lim) begin
            settle(1);
            n++;
        end
        if (n >= lim) begin
            errors++;
            $display("CHECK FAILED at %0t: wait %0d ran out", $time, sel);
            complete_run();
        end
    endtask

    task automatic do_write(input logic [11:0] v);
        @(posedge clk);
        do_wdata <= v;
        do_wr <= 1'b1;
        @(posedge clk);
        do_wr <= 1'b0;
        settle(1);
    endtask

    // Junk in the unused upper bits must not matter
    task automatic ao_write(input logic [1:0] ch, input logic [11:0] code);
        @(posedge clk);
        ao_wdata <= {14'h2aaa, ch, 4'hf, code};
        ao_wr <= 1'b1;
        @(posedge clk);
        ao_wr <= 1'b0;
        settle(1);
    endtask

    task automatic tmr_cmd(input logic ana, input iow_pkg::iow_tmr_cmd_t c);
        @(posedge clk);
        if (ana) begin
            acmd <= c;
        end else begin
            dcmd <= c;
        end
        @(posedge clk);
        acmd <= '0;
        dcmd <= '0;
        settle(1);
    endtask

    initial begin
        settle(11);
        chk({do_latch, do_pins}, 24'h0, "do rst");
        chk(ao_out, {4{12'h800}}, "ao rst");
        chk(ao_ready, 1'b1, "rdy rst");
        @(posedge clk);
        rst_n <= 1'b1;
        settle(1);
        chk(di_state, 10'h2a5, "di first");
        @(posedge clk);
        di_pins <= 10'h15a;
        settle(2);
        chk(di_state, 10'h15a, "di follow");
        do_write(12'ha5c);
        chk({do_latch, do_pins}, {2{12'ha5c}}, "do wr");
        ao_write(2'h2, 12'h5a3);
        chk(ao_ready, 1'b0, "rdy busy");
        ao_write(2'h2, 12'h123);
        wait_on(0, 2000);
        // Busy for the full count; the wait opens four edges in
        chk(n, iow_pkg::AO_BUSY_CYC - 4, "busy len");
        chk(ao_out, {12'h800, 12'h5a3, 24'h800800}, "ao ch2");
        settle(5);
        chk(ao_ready, 1'b1, "late wr");
        for (int ch = 0; ch < 4; ch++) begin
            ao_write(ch[1:0], 12'h100 + 12'(ch));
            wait_on(0, 1000);
        end
        chk(ao_out, 48'h103102101100, "ao all");
        @(posedge clk);
        diag_en <= 2'b10;
        short_mask <= 12'h010;
        do_write(12'h010);
        settle(4);
        chk(diag, 2'b10, "short");
        chk({do_latch, do_pins}, 24'h010000, "short cut");
        chk(irq, 1'b1, "irq fault");
        @(posedge clk);
        short_mask <= 12'h000;
        overtemp <= 3'h4;
        settle(4);
        chk(diag, 2'b10, "overtemp");
        chk(do_pins, 12'h010, "ot group");
        @(posedge clk);
        overtemp <= 3'h0;
        supply_low <= 1'b1;
        settle(4);
        chk(diag, 2'b01, "supply");
        chk(irq, 1'b0, "irq masked");
        @(posedge clk);
        diag_en <= 2'b01;
        settle(4);
        chk(irq, 1'b1, "irq supply");
        @(posedge clk);
        supply_low <= 1'b0;
        diag_en <= 2'b00;
        dcfg <= {1'b1, iow_pkg::UNIT_US, 12'h005, 1'b1};
        settle(4);
        tmr_cmd(1'b0, 4'h8);
        chk(dstat.running, 1'b1, "dig run");
        chk(dstat.reload, 12'h005, "dig reload");
        wait_on(3, 100);
        do_write(12'hfff);
        chk(dstat.count >= 12'h004, 1'b1, "wr reload");
        wait_on(3, 100);
        tmr_cmd(1'b0, 4'h2);
        chk(dstat.count >= 12'h004, 1'b1, "trig");
        chk(do_latch, 12'hfff, "trig keeps do");
        wait_on(1, 100);
        chk({dstat.running, dstat.irq_flag}, 2'b01, "dig exp");
        settle(1);
        chk({do_latch, do_pins}, 24'h0, "wd clear");
        chk(irq, 1'b1, "irq tmr");
        tmr_cmd(1'b0, 4'h1);
        settle(1);
        chk({dstat.irq_flag, irq}, 2'b00, "ack");
        do_write(12'h3c3);
        @(posedge clk);
        dcfg <= {1'b0, iow_pkg::UNIT_MS, 12'h001, 1'b0};
        tmr_cmd(1'b0, 4'h8);
        wait_on(5, 9000);
        chk(n > 3990, 1'b1, "ms base");
        chk(dstat.count, 12'h001, "auto reload");
        chk({dstat.running, dstat.timed_out, irq}, 3'b100, "plain");
        chk(do_latch, 12'h3c3, "plain keeps do");
        @(posedge clk);
        dcfg <= {1'b0, 2'h0, 12'h003, 1'b0};
        tmr_cmd(1'b0, 4'h8);
        settle(40);
        chk(dstat.count, 12'h003, "unit halt");
        tmr_cmd(1'b0, 4'h4);
        chk(dstat.running, 1'b0, "dig stop");
        @(posedge clk);
        acfg <= {1'b1, iow_pkg::UNIT_US, 12'h0fa, 1'b0};
        tmr_cmd(1'b1, 4'h8);
        chk(astat.reload, 12'h0fa, "ana reload");
        wait_on(4, 1200);
        ao_write(2'h0, 12'h7ff);
        chk(astat.count >= 12'h0f9, 1'b1, "ao reload");
        wait_on(0, 1000);
        chk(ao_out[0], 12'h7ff, "ao0");
        tmr_cmd(1'b1, 4'h2);
        chk(astat.count >= 12'h0f9, 1'b1, "ana trig");
        chk(ao_out[0], 12'h7ff, "trig keeps ao");
        wait_on(2, 1200);
        chk({astat.running, astat.irq_flag}, 2'b01, "ana exp");
        settle(1);
        chk(ao_out, {4{12'h800}}, "ao wd");
        complete_run();
    end
endmodule // iow_io_guard_tb_top

// *** src/iow_dac_ready.sv ***
// Analog setpoint holding registers with converter-ready handshake
`timescale 1ns/10ps
module iow_dac_ready (
    input logic clk,
    input logic rst_n,
    input logic wr,
    input logic [31:0] wdata,
    input logic wd_clear,
    output logic ready,
    output logic [3:0][11:0] ao,
    output logic accepted
);
    localparam int RDY_WAIT = iow_pkg::AO_BUSY_CYC - 7;
    typedef struct packed {
        logic [3:0][11:0] ao;
        logic [11:0] pend;
        logic [1:0] ch;
        logic ready;
        logic [9:0] cnt;
        logic accepted;
    } iow_dac_state_t;
    iow_dac_state_t st_ff, nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.accepted = 1'b0;
        if (wd_clear) begin
            // Pending update dropped so a stale code cannot follow the clear
            nxt_st.ao = {iow_pkg::AO_N{iow_pkg::AO_ZERO_CODE}};
            nxt_st.ready = 1'b1;
        end else if (!st_ff.ready) begin
            if (st_ff.cnt == 10'h000) begin
                nxt_st.ao[st_ff.ch] = st_ff.pend;
                nxt_st.ready = 1'b1;
            end else begin
                nxt_st.cnt = st_ff.cnt - 10'h001;
            end
        end else if (wr) begin
            nxt_st.pend = wdata[11:0];
            nxt_st.ch = wdata[iow_pkg::AO_CH_LSB +: 2];
            nxt_st.ready = 1'b0;
            nxt_st.cnt = 10'(iow_pkg::AO_BUSY_CYC - 1);
            nxt_st.accepted = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
            st_ff.ao <= {iow_pkg::AO_N{iow_pkg::AO_ZERO_CODE}};
            st_ff.ready <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign ready = st_ff.ready;
    assign ao = st_ff.ao;
    assign accepted = st_ff.accepted;

    property p_busy;
        @(posedge clk) disable iff (!rst_n)
        wr && ready && !wd_clear |=> !ready;
    endproperty
    a_busy: assert property (p_busy)
        else $error("ready stayed high after accepted write");
    property p_time;
        @(posedge clk) disable iff (!rst_n || wd_clear)
        $fell(ready) |-> !ready [*8] ##[1:RDY_WAIT] ready;
    endproperty
    a_time: assert property (p_time)
        else $error("converter busy time wrong");
    property p_ignore;
        @(posedge clk) disable iff (!rst_n)
        !ready && wr && !wd_clear |=> $stable(st_ff.pend);
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("write during busy was not ignored");
    property p_zero;
        @(posedge clk) disable iff (!rst_n)
        wd_clear |=> ao == {iow_pkg::AO_N{iow_pkg::AO_ZERO_CODE}} && ready;
    endproperty
    a_zero: assert property (p_zero)
        else $error("analog outputs not zeroed on expiry");
endmodule // iow_dac_ready

// *** src/iow_guard_timer.sv ***
// 12-bit down-counting timer usable as a watchdog
`timescale 1ns/10ps
module iow_guard_timer (
    input logic clk,
    input logic rst_n,
    input iow_pkg::iow_tmr_cfg_t cfg,
    input iow_pkg::iow_tmr_cmd_t cmd,
    input logic set_trig,
    input logic tick_us,
    input logic tick_ms,
    input logic tick_s,
    output iow_pkg::iow_tmr_stat_t stat,
    output logic wd_expire
);
    typedef struct packed {
        iow_pkg::iow_tmr_stat_t stat;
        logic wd_expire;
    } iow_gt_state_t;
    iow_gt_state_t st_ff, nxt_st;
    logic tick;

    always_comb begin
        unique case (cfg.guard_delay_unit)
            iow_pkg::UNIT_US: tick = tick_us;
            iow_pkg::UNIT_MS: tick = tick_ms;
            iow_pkg::UNIT_S: tick = tick_s;
            2'h0: tick = 1'b0;
        endcase
        nxt_st = st_ff;
        nxt_st.wd_expire = 1'b0;
        // Ack first so a same-cycle timeout still sets the flag
        if (cmd.ack) begin
            nxt_st.stat.irq_flag = 1'b0;
        end
        if (cmd.stop) begin
            nxt_st.stat.running = 1'b0;
        end else if (cmd.start) begin
            nxt_st.stat.count = cfg.guard_delay_count;
            nxt_st.stat.reload = cfg.guard_delay_count;
            nxt_st.stat.running = 1'b1;
            nxt_st.stat.timed_out = 1'b0;
        end else if (st_ff.stat.running) begin
            if (cfg.wdog && (cmd.trig || set_trig)) begin
                nxt_st.stat.count = st_ff.stat.reload;
            end else if (tick) begin
                if (st_ff.stat.count == 12'h000) begin
                    nxt_st.stat.irq_flag = 1'b1;
                    if (cfg.wdog) begin
                        nxt_st.stat.running = 1'b0;
                        nxt_st.stat.timed_out = 1'b1;
                        nxt_st.wd_expire = 1'b1;
                    end else begin
                        nxt_st.stat.count = st_ff.stat.reload;
                    end
                end else begin
                    nxt_st.stat.count = st_ff.stat.count - 12'h001;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign stat = st_ff.stat;
    assign wd_expire = st_ff.wd_expire;

    property p_wd_stop;
        @(posedge clk) disable iff (!rst_n)
        wd_expire |-> !stat.running && stat.timed_out;
    endproperty
    a_wd_stop: assert property (p_wd_stop)
        else $error("watchdog expiry left timer running");
    property p_trig;
        @(posedge clk) disable iff (!rst_n)
        stat.running && cfg.wdog && !cmd.stop && !cmd.start &&
            (cmd.trig || set_trig) |=> stat.count == $past(stat.reload);
    endproperty
    a_trig: assert property (p_trig)
        else $error("trigger did not reload the count");
    property p_periodic;
        @(posedge clk) disable iff (!rst_n)
        stat.running && !cfg.wdog && !cmd.stop |=> stat.running;
    endproperty
    a_periodic: assert property (p_periodic)
        else $error("plain timer stopped on its own");
endmodule // iow_guard_timer

// *** src/iow_io_guard.sv ***
// Output-side control: digital/analog guard timers, diagnostics, inputs
//
// Contract
// - Four analog channels, 12-bit setpoint each
// - 32-bit writes update the addressed channel
// - Converter-ready status bit is readable
// - Writes ignored during 4.5 us update interval
// - Analog channels at zero volts after reset
// - Twelve digital outputs, one means on
// - Exactly two digital output diagnostic bits
// - Fault flag on short or group overtemperature
// - Supply flag when external supply below 5 V
// - Both diagnostics readable and can interrupt
// - Digital timer: 12-bit down counter, timeout interrupt
// - Count, reload, status, interrupt readable per timer
// - Digital watchdog expiry clears digital outputs
// - Digital output write reloads running digital watchdog
// - Trigger command reloads digital watchdog only
// - Each timer picks one of three time bases
// - Analog timer: separate 12-bit down counter
// - Analog watchdog expiry zeroes analog outputs
// - Analog setpoint write reloads running analog watchdog
// - Trigger command reloads analog watchdog only
// - Running and timed-out state readable per timer
// - Digital inputs readable straight after power-up
// - Each timer set as timer or watchdog
// - Delay 0 to 4095 in us, ms or s
`timescale 1ns/10ps
module iow_io_guard #(
    parameter int US_CYCLES = iow_pkg::US_CYC
) (
    input logic CORE_CLK,
    input logic RESET_N,
    input logic DO_WR,
    input logic [11:0] DO_WDATA,
    output logic [11:0] DO_LATCH,
    output logic [11:0] DO_PINS,
    input logic [9:0] DI_PINS,
    output logic [9:0] DI_STATE,
    input logic [11:0] SC_FAULT,
    input logic [2:0] OVERTEMP,
    input logic SUPPLY_LOW,
    input iow_pkg::iow_diag_t DIAG_IRQ_EN,
    output iow_pkg::iow_diag_t DIAG,
    input logic AO_WR,
    input logic [31:0] AO_WDATA,
    output logic AO_READY,
    output logic [3:0][11:0] AO_OUT,
    input iow_pkg::iow_tmr_cfg_t DIG_GUARD_CFG,
    input iow_pkg::iow_tmr_cmd_t DIG_GUARD_CMD,
    output iow_pkg::iow_tmr_stat_t DIG_GUARD_STAT,
    input iow_pkg::iow_tmr_cfg_t ANA_GUARD_CFG,
    input iow_pkg::iow_tmr_cmd_t ANA_GUARD_CMD,
    output iow_pkg::iow_tmr_stat_t ANA_GUARD_STAT,
    output logic IRQ
);
    typedef struct packed {
        logic [11:0] do_latch;
        logic [11:0] do_pins;
        logic [9:0] di;
        iow_pkg::iow_diag_t diag;
        logic irq;
        logic [7:0] us_cnt;
        logic [9:0] ms_cnt;
        logic [9:0] s_cnt;
        logic tick_us;
        logic tick_ms;
        logic tick_s;
    } iow_top_state_t;

    iow_top_state_t st_ff, nxt_st;
    logic dig_wd_exp;
    logic ana_wd_exp;
    logic ao_accepted;

    // Time bases: one microsecond prescaler, then two stages of 1000
    always_comb begin
        nxt_st = st_ff;
        nxt_st.tick_us = 1'b0;
        nxt_st.tick_ms = 1'b0;
        nxt_st.tick_s = 1'b0;
        if (st_ff.us_cnt == 8'(US_CYCLES - 1)) begin
            nxt_st.us_cnt = 8'h00;
            nxt_st.tick_us = 1'b1;
            if (st_ff.ms_cnt == 10'(iow_pkg::MS_US - 1)) begin
                nxt_st.ms_cnt = 10'h000;
                nxt_st.tick_ms = 1'b1;
                if (st_ff.s_cnt == 10'(iow_pkg::S_MS - 1)) begin
                    nxt_st.s_cnt = 10'h000;
                    nxt_st.tick_s = 1'b1;
                end else begin
                    nxt_st.s_cnt = st_ff.s_cnt + 10'h001;
                end
            end else begin
                nxt_st.ms_cnt = st_ff.ms_cnt + 10'h001;
            end
        end else begin
            nxt_st.us_cnt = st_ff.us_cnt + 8'h01;
        end

        // Expiry wins over a same-cycle host write
        if (dig_wd_exp) begin
            nxt_st.do_latch = iow_pkg::DO_RESET;
        end else if (DO_WR) begin
            nxt_st.do_latch = DO_WDATA;
        end

        // Protection switches pins off but keeps the host's latch
        for (int i = 0; i < iow_pkg::DO_N; i++) begin
            nxt_st.do_pins[i] = nxt_st.do_latch[i] & ~SC_FAULT[i] &
                ~OVERTEMP[i / iow_pkg::OT_GROUP] & ~SUPPLY_LOW;
        end

        nxt_st.di = DI_PINS;

        nxt_st.diag.fault = (|SC_FAULT) | (|OVERTEMP);
        nxt_st.diag.supply = SUPPLY_LOW;

        // Interrupt follows registered sources, one cycle behind
        nxt_st.irq = (DIAG_IRQ_EN.fault & st_ff.diag.fault) |
            (DIAG_IRQ_EN.supply & st_ff.diag.supply) |
            (DIG_GUARD_CFG.irq_en & DIG_GUARD_STAT.irq_flag) |
            (ANA_GUARD_CFG.irq_en & ANA_GUARD_STAT.irq_flag);
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_ff <= '0;
            st_ff.do_latch <= iow_pkg::DO_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign DO_LATCH = st_ff.do_latch;
    assign DO_PINS = st_ff.do_pins;
    assign DI_STATE = st_ff.di;
    assign DIAG = st_ff.diag;
    assign IRQ = st_ff.irq;

    // Digital outputs guard; any digital write retriggers it
    iow_guard_timer digital_guard_timer (
        .clk(CORE_CLK),
        .rst_n(RESET_N),
        .cfg(DIG_GUARD_CFG),
        .cmd(DIG_GUARD_CMD),
        .set_trig(DO_WR),
        .tick_us(st_ff.tick_us),
        .tick_ms(st_ff.tick_ms),
        .tick_s(st_ff.tick_s),
        .stat(DIG_GUARD_STAT),
        .wd_expire(dig_wd_exp)
    );

    // Analog outputs guard; only accepted setpoint writes retrigger
    iow_guard_timer analog_guard_timer (
        .clk(CORE_CLK),
        .rst_n(RESET_N),
        .cfg(ANA_GUARD_CFG),
        .cmd(ANA_GUARD_CMD),
        .set_trig(ao_accepted),
        .tick_us(st_ff.tick_us),
        .tick_ms(st_ff.tick_ms),
        .tick_s(st_ff.tick_s),
        .stat(ANA_GUARD_STAT),
        .wd_expire(ana_wd_exp)
    );

    iow_dac_ready dac_ready (
        .clk(CORE_CLK),
        .rst_n(RESET_N),
        .wr(AO_WR),
        .wdata(AO_WDATA),
        .wd_clear(ana_wd_exp),
        .ready(AO_READY),
        .ao(AO_OUT),
        .accepted(ao_accepted)
    );

    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RESET_N);

    property p_do_set;
        DO_WR && !dig_wd_exp |=> DO_LATCH == $past(DO_WDATA);
    endproperty
    a_do_set: assert property (p_do_set)
        else $error("digital write not latched");

    property p_do_wd;
        dig_wd_exp |=> DO_LATCH == '0 && DO_PINS == '0;
    endproperty
    a_do_wd: assert property (p_do_wd)
        else $error("digital outputs not cleared on expiry");

    property p_supply;
        SUPPLY_LOW |=> DIAG.supply && DO_PINS == '0;
    endproperty
    a_supply: assert property (p_supply)
        else $error("supply diagnostic or pin cutoff missing");

    property p_fault;
        (|SC_FAULT) || (|OVERTEMP) |=> DIAG.fault;
    endproperty
    a_fault: assert property (p_fault)
        else $error("fault diagnostic not raised");

    property p_irq;
        IRQ |-> $past((DIAG_IRQ_EN.fault && DIAG.fault) ||
            (DIAG_IRQ_EN.supply && DIAG.supply) ||
            (DIG_GUARD_CFG.irq_en && DIG_GUARD_STAT.irq_flag) ||
            (ANA_GUARD_CFG.irq_en && ANA_GUARD_STAT.irq_flag));
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt without an enabled source");

    property p_di;
        $past(RESET_N) |-> DI_STATE == $past(DI_PINS);
    endproperty
    a_di: assert property (p_di)
        else $error("digital input not sampled");

    property p_us_tick;
        st_ff.tick_us |-> $past(st_ff.us_cnt) == 8'(US_CYCLES - 1);
    endproperty
    a_us_tick: assert property (p_us_tick)
        else $error("microsecond tick too frequent");

    property p_short_cut;
        (|SC_FAULT) |=> (DO_PINS & $past(SC_FAULT)) == 12'h000;
    endproperty
    a_short_cut: assert property (p_short_cut)
        else $error("shorted output still driven");

    property p_ot_cut;
        (|OVERTEMP) |=> (DO_PINS & {{4{$past(OVERTEMP[2])}},
            {4{$past(OVERTEMP[1])}}, {4{$past(OVERTEMP[0])}}}) == 12'h000;
    endproperty
    a_ot_cut: assert property (p_ot_cut)
        else $error("hot output group still driven");

    property p_pins_follow;
        !(|SC_FAULT) && !(|OVERTEMP) && !SUPPLY_LOW |=> DO_PINS == DO_LATCH;
    endproperty
    a_pins_follow: assert property (p_pins_follow)
        else $error("output pins differ from latch");

    property p_ana_exp;
        ana_wd_exp |-> ANA_GUARD_STAT.timed_out && !ANA_GUARD_STAT.running;
    endproperty
    a_ana_exp: assert property (p_ana_exp)
        else $error("analog expiry state not shown");

    property p_dig_flag;
        dig_wd_exp |-> DIG_GUARD_STAT.irq_flag;
    endproperty
    a_dig_flag: assert property (p_dig_flag)
        else $error("digital timeout flag missing");

    property p_ana_flag;
        ana_wd_exp |-> ANA_GUARD_STAT.irq_flag;
    endproperty
    a_ana_flag: assert property (p_ana_flag)
        else $error("analog timeout flag missing");

    property p_ao_busy;
        AO_WR && AO_READY && !ana_wd_exp |=> !AO_READY;
    endproperty
    a_ao_busy: assert property (p_ao_busy)
        else $error("converter ready after accepted write");

    property p_ao_hold;
        AO_READY && !AO_WR && !ana_wd_exp |=> $stable(AO_OUT);
    endproperty
    a_ao_hold: assert property (p_ao_hold)
        else $error("analog output moved without update");

    property p_dig_ack;
        DIG_GUARD_CMD.ack && !DIG_GUARD_STAT.running |=>
            !DIG_GUARD_STAT.irq_flag;
    endproperty
    a_dig_ack: assert property (p_dig_ack)
        else $error("acknowledge left timer flag set");

    property p_dig_start;
        DIG_GUARD_CMD.start && !DIG_GUARD_CMD.stop |=>
            DIG_GUARD_STAT.running && DIG_GUARD_STAT.count ==
            $past(DIG_GUARD_CFG.guard_delay_count);
    endproperty
    a_dig_start: assert property (p_dig_start)
        else $error("start did not load the delay");

    property p_dig_stop;
        DIG_GUARD_CMD.stop |=> !DIG_GUARD_STAT.running;
    endproperty
    a_dig_stop: assert property (p_dig_stop)
        else $error("stop left timer running");

    property p_tick_ms;
        st_ff.tick_ms |-> st_ff.tick_us;
    endproperty
    a_tick_ms: assert property (p_tick_ms)
        else $error("millisecond tick off the microsecond grid");

    property p_tick_s;
        st_ff.tick_s |-> st_ff.tick_ms;
    endproperty
    a_tick_s: assert property (p_tick_s)
        else $error("second tick off the millisecond grid");

    property p_irq_fault;
        DIAG_IRQ_EN.fault && DIAG.fault |=> IRQ;
    endproperty
    a_irq_fault: assert property (p_irq_fault)
        else $error("enabled fault gave no interrupt");

    property p_ana_trig;
        ANA_GUARD_STAT.running && ANA_GUARD_CFG.wdog && ao_accepted &&
            ANA_GUARD_CMD == '0 |=> ANA_GUARD_STAT.count ==
            ANA_GUARD_STAT.reload;
    endproperty
    a_ana_trig: assert property (p_ana_trig)
        else $error("setpoint write did not reload");

    property p_halt;
        DIG_GUARD_CFG.guard_delay_unit == 2'h0 && DIG_GUARD_CMD == '0 &&
            !DO_WR |=> $stable(DIG_GUARD_STAT.count);
    endproperty
    a_halt: assert property (p_halt)
        else $error("timer counted with no time base");

    property p_c_dig_wd;
        dig_wd_exp ##1 DO_LATCH == '0;
    endproperty
    c_dig_wd: cover property (p_c_dig_wd);

    property p_c_ao_write;
        AO_WR && AO_READY ##1 !AO_READY;
    endproperty
    c_ao_write: cover property (p_c_ao_write);

    property p_c_irq;
        !IRQ ##1 IRQ;
    endproperty
    c_irq: cover property (p_c_irq);

    property p_c_ana_wd;
        ana_wd_exp;
    endproperty
    c_ana_wd: cover property (p_c_ana_wd);
endmodule // iow_io_guard

// *** src/iow_pkg.sv ***
// Shared constants and carrier types for the I/O guard timer block
package iow_pkg;
    localparam int CLK_PERIOD_NS = 5;
    localparam int US_NS = 1000;
    localparam int US_CYC = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MS_US = 1000;
    localparam int S_MS = 1000;
    localparam int AO_READY_NS = 4500;
    localparam int AO_BUSY_CYC =
        (AO_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DO_N = 12;
    localparam int DI_N = 10;
    localparam int AO_N = 4;
    localparam int AO_W = 12;
    localparam int TMR_W = 12;
    localparam int OT_GROUP = 4;
    localparam int OT_N = DO_N / OT_GROUP;
    localparam int AO_CH_LSB = 16;
    localparam logic [11:0] AO_ZERO_CODE = 12'h800;
    localparam logic [11:0] DO_RESET = 12'h000;
    localparam logic [1:0] UNIT_US = 2'h1;
    localparam logic [1:0] UNIT_MS = 2'h2;
    localparam logic [1:0] UNIT_S = 2'h3;
    typedef struct packed {
        logic wdog;
        logic [1:0] guard_delay_unit;
        logic [11:0] guard_delay_count;
        logic irq_en;
    } iow_tmr_cfg_t;
    typedef struct packed {
        logic start;
        logic stop;
        logic trig;
        logic ack;
    } iow_tmr_cmd_t;
    typedef struct packed {
        logic [11:0] count;
        logic [11:0] reload;
        logic running;
        logic timed_out;
        logic irq_flag;
    } iow_tmr_stat_t;
    typedef struct packed {
        logic fault;
        logic supply;
    } iow_diag_t;
endpackage
